// file: logic/bpe_pkg.sv
package bpe_pkg;

	// Register count and printed offsets; byte address is four times the offset.
	localparam int         REG_COUNT = 11;
	localparam logic [7:0] REG_OFFSET [REG_COUNT] = '{
		8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
	localparam logic [7:0] REG_RESET [REG_COUNT] = '{
		8'h00, 8'h0e, 8'h06, 8'h00, 8'h02, 8'h20, 8'h80, 8'h1c, 8'h01, 8'h08, 8'hc0};
	// Writable bits; the rest read as the fixed pattern below.
	localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
		8'h77, 8'hff, 8'h06, 8'h4e, 8'h03, 8'h0c, 8'hff, 8'h9c, 8'h77, 8'hff, 8'hff};
	localparam logic [7:0] REG_FIXED [REG_COUNT] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// Indices of the registers in the table above.
	localparam int IDX_PULSE_CTRL = 0;
	localparam int IDX_DIVIDER    = 1;
	localparam int IDX_SAT_PROT   = 2;
	localparam int IDX_ENH_FUNC   = 3;
	localparam int IDX_CN_LEVEL   = 4;
	localparam int IDX_SRE_MID    = 5;
	localparam int IDX_MEAN       = 6;
	localparam int IDX_SRE_EN     = 7;
	localparam int IDX_SRE_STEPS  = 8;
	localparam int IDX_SRE_FRAMES = 9;
	localparam int IDX_SRE_GAIN   = 10;

	// Internal pulse source and system clock rates, in MHz.
	localparam int         SRC_MHZ      = 32;
	localparam int         SYS_MHZ      = 100;
	localparam logic [6:0] SRC_INC      = 7'(SRC_MHZ);
	localparam logic [6:0] SRC_MOD      = 7'(SYS_MHZ);
	// Highest legal resolution code and shortest step duration in frames.
	localparam logic [2:0] RES_CODE_MAX = 3'h4;
	localparam logic [7:0] MIN_FRAMES   = 8'h02;

	// Sunlight medium-level decode.
	typedef enum logic [1:0] {
		BPE_LVL_MED  = 2'h0,
		BPE_LVL_HIGH = 2'h1,
		BPE_LVL_LOW  = 2'h2
	} bpe_level_t;

	// Decoded enhancement settings handed to the pixel pipeline.
	typedef struct packed {
		logic       oversat_protect_enable;
		logic       skin_protect_enable;
		logic       auto_mean;
		logic [7:0] image_mean;
		logic       contrast_enable;
		logic       contrast_increase;
		logic       contrast_decrease;
		logic [1:0] contrast_level;
		logic       sharpness_enable;
		bpe_level_t sunlight_mid_level;
		logic       sunlight_hysteresis_enable;
		logic       sunlight_dimming_enable;
		logic       sunlight_satcomp_enable;
		logic       sunlight_contrast_enable;
		logic [2:0] sunlight_offset_value;
		logic [2:0] sunlight_satcomp_gain;
		logic [4:0] sunlight_hysteresis_limit;
	} bpe_enh_t;

endpackage

// file: logic/bpe_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module bpe_ctrl (
	input  wire  logic              sys_clk,
	input  wire  logic              sys_rst,
	input  wire  logic              ce,
	input  wire  logic              psel,
	input  wire  logic              penable,
	input  wire  logic              pwrite,
	input  wire  logic [7:0]        paddr,
	input  wire  logic [31:0]       pwdata,
	input  wire  logic [3:0]        pstrb,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire  logic              backlight_control_on,
	input  wire  logic              sleep_in,
	input  wire  logic [11:0]       pulse_duty,
	input  wire  logic [7:0]        auto_mean_value,
	input  wire  logic              frame_tick,
	input  wire  logic              dim_start,
	output logic                    backlight_on_out,
	output logic                    backlight_pulse_out,
	output logic                    dim_active,
	output logic [8:0]              dim_step,
	output bpe_pkg::bpe_enh_t       enh_cfg
);
	import bpe_pkg::*;

	typedef enum logic [1:0] {
		BPE_DIM_IDLE = 2'b01,
		BPE_DIM_RUN  = 2'b10
	} bpe_dim_t;

	logic [7:0]  regs [REG_COUNT];   // Register file, one byte per entry.
	logic [REG_COUNT-1:0] hit;       // One-hot address decode.
	logic        access;             // Access phase that completes this cycle.
	logic [6:0]  src_acc;            // Fractional accumulator for the 32 MHz tick.
	logic [7:0]  src_sum;            // Accumulator plus increment, one bit wider.
	logic        src_tick;           // One cycle per 32 MHz source period.
	logic [7:0]  act_div;            // Divider in use for the running period.
	logic [2:0]  act_res;            // Resolution code in use for the running period.
	logic [7:0]  pre_cnt;            // Source ticks within one resolution step.
	logic [11:0] res_cnt;            // Resolution step within the period.
	logic [11:0] res_max;            // Last resolution step for act_res.
	logic        wave;               // Internal pulse waveform before polarity.
	logic        boundary;           // Last tick of the running period.
	bpe_dim_t    dim_state;          // Dimming sequencer state.
	logic [7:0]  frame_cnt;          // Frames spent in the current step.
	logic [7:0]  frame_len;          // Frames per step after clamping.
	logic [8:0]  step_last;          // Index of the final dimming step.

	// The bus completes only while the block runs, so a write is never lost
	// to a frozen clock enable.
	assign pready = ce;
	assign access = psel && penable && ce;

	// Decode the word address; every printed offset sits at four times its value.
	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
			assign hit[gi] = (paddr == {REG_OFFSET[gi][5:0], 2'b00});
			// Writes land in any power state; sleep does not gate them.
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					regs[gi] <= REG_RESET[gi];
				end else if (access && pwrite && hit[gi] && pstrb[0]) begin
					regs[gi] <= (pwdata[7:0] & REG_WMASK[gi]) | REG_FIXED[gi];
				end
			end
		end
	endgenerate

	// Read data is registered; unmapped addresses answer with an error and zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable && ce) begin
			prdata  <= 32'h0000_0000;
			pslverr <= (hit == '0);
			for (int i = 0; i < REG_COUNT; i++) begin
				if (hit[i] && !pwrite) begin
					prdata <= {24'h00_0000, regs[i]};
				end
			end
		end
	end

	// Backlight-on level: enable gives the active level, polarity picks it.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			backlight_on_out <= 1'b0;
		end else if (ce) begin
			backlight_on_out <= regs[IDX_PULSE_CTRL][0] ^ regs[IDX_PULSE_CTRL][1];
		end
	end

	// A 32 MHz tick from the 100 MHz clock by adding 32 modulo 100; jitter is
	// one system cycle, well inside the source's own tolerance. The sum is one
	// bit wider than the accumulator, since 96 + 32 would wrap in seven bits.
	assign src_sum  = {1'b0, src_acc} + {1'b0, SRC_INC};
	assign src_tick = src_sum >= {1'b0, SRC_MOD};
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			src_acc <= 7'h00;
		end else if (ce) begin
			src_acc <= src_tick ? 7'(src_sum - {1'b0, SRC_MOD}) : src_sum[6:0];
		end
	end

	// Resolution 4096 shifted right by the code gives the step count.
	assign res_max  = 12'(13'h1000 >> act_res) - 12'h001;
	assign boundary = src_tick && (pre_cnt == act_div) && (res_cnt == res_max);

	// Period counters: divider+1 ticks per step, res_max+1 steps per period.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_cnt <= 8'h00;
			res_cnt <= 12'h000;
		end else if (ce && !backlight_control_on) begin
			// Parked at the period start while the pin is static, so the first
			// period after switch-on is whole.
			pre_cnt <= 8'h00;
			res_cnt <= 12'h000;
		end else if (ce && src_tick) begin
			if (pre_cnt == act_div) begin
				pre_cnt <= 8'h00;
				res_cnt <= (res_cnt == res_max) ? 12'h000 : res_cnt + 12'h001;
			end else begin
				pre_cnt <= pre_cnt + 8'h01;
			end
		end
	end

	// New divider and resolution take effect only at a period boundary, so a
	// period is never cut short; a reserved code keeps the previous one. While the
	// control is off the pin is static, so settings follow the registers at once.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			act_div <= REG_RESET[IDX_DIVIDER];
			act_res <= REG_RESET[IDX_PULSE_CTRL][6:4];
		end else if (ce && (boundary || !backlight_control_on)) begin
			act_div <= regs[IDX_DIVIDER];
			if (regs[IDX_PULSE_CTRL][6:4] <= RES_CODE_MAX) begin
				act_res <= regs[IDX_PULSE_CTRL][6:4];
			end
		end
	end

	// Duty is given at 4096 resolution and scaled to the active resolution.
	assign wave = res_cnt < (pulse_duty >> act_res);

	// Pulse pin: static polarity level when off, waveform xor polarity when on.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			backlight_pulse_out <= 1'b0;
		end else if (ce) begin
			if (backlight_control_on) begin
				backlight_pulse_out <= wave ^ regs[IDX_PULSE_CTRL][2];
			end else begin
				backlight_pulse_out <= regs[IDX_PULSE_CTRL][2];
			end
		end
	end

	// Decoded settings; pure functions of the stored registers, except image_mean, which takes auto_mean_value in auto mode.
	always_comb begin
		enh_cfg.oversat_protect_enable     = regs[IDX_SAT_PROT][2];
		enh_cfg.skin_protect_enable        = regs[IDX_SAT_PROT][1];
		enh_cfg.auto_mean                  = regs[IDX_ENH_FUNC][6];
		enh_cfg.image_mean                 = regs[IDX_ENH_FUNC][6] ?
			auto_mean_value : regs[IDX_MEAN];
		enh_cfg.contrast_enable            = regs[IDX_ENH_FUNC][3];
		enh_cfg.contrast_increase          = regs[IDX_ENH_FUNC][3] && !regs[IDX_ENH_FUNC][2];
		enh_cfg.contrast_decrease          = regs[IDX_ENH_FUNC][3] && regs[IDX_ENH_FUNC][2];
		enh_cfg.contrast_level             = regs[IDX_CN_LEVEL][1:0];
		enh_cfg.sharpness_enable           = regs[IDX_ENH_FUNC][1];
		unique case (regs[IDX_SRE_MID][3:2])
			2'b01: begin
				enh_cfg.sunlight_mid_level = BPE_LVL_HIGH;
			end
			2'b10: begin
				enh_cfg.sunlight_mid_level = BPE_LVL_LOW;
			end
			default: begin
				enh_cfg.sunlight_mid_level = BPE_LVL_MED;
			end
		endcase
		enh_cfg.sunlight_hysteresis_enable = regs[IDX_SRE_EN][7];
		enh_cfg.sunlight_dimming_enable    = regs[IDX_SRE_EN][4];
		enh_cfg.sunlight_satcomp_enable    = regs[IDX_SRE_EN][3];
		enh_cfg.sunlight_contrast_enable   = regs[IDX_SRE_EN][2];
		enh_cfg.sunlight_offset_value      = regs[IDX_SRE_STEPS][6:4];
		enh_cfg.sunlight_satcomp_gain      = regs[IDX_SRE_GAIN][7:5];
		enh_cfg.sunlight_hysteresis_limit  = regs[IDX_SRE_GAIN][4:0];
	end

	// Step count is two to (code+1); frame counts below two behave as two.
	assign step_last = 9'((10'h002 << regs[IDX_SRE_STEPS][2:0]) - 10'h001);
	assign frame_len = (regs[IDX_SRE_FRAMES] < MIN_FRAMES) ? MIN_FRAMES
		: regs[IDX_SRE_FRAMES];

	// Dimming sequencer: walks dim_step from 0 to step_last, frame_len frames each.
	// A start while running is ignored so a transition is never restarted midway.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dim_state <= BPE_DIM_IDLE;
			dim_step  <= 9'h000;
			frame_cnt <= 8'h00;
		end else if (ce) begin
			unique case (dim_state)
				BPE_DIM_IDLE: begin
					if (dim_start && regs[IDX_SRE_EN][4]) begin
						dim_state <= BPE_DIM_RUN;
						dim_step  <= 9'h000;
						frame_cnt <= 8'h00;
					end
				end
				BPE_DIM_RUN: begin
					if (frame_tick) begin
						if (frame_cnt >= frame_len - 8'h01) begin
							frame_cnt <= 8'h00;
							if (dim_step >= step_last) begin
								dim_state <= BPE_DIM_IDLE;
							end else begin
								dim_step <= dim_step + 9'h001;
							end
						end else begin
							frame_cnt <= frame_cnt + 8'h01;
						end
					end
				end
				default: begin
					dim_state <= BPE_DIM_IDLE;
				end
			endcase
		end
	end
	assign dim_active = (dim_state == BPE_DIM_RUN);

	property p_on_level;
		@(posedge sys_clk) disable iff (sys_rst)
		ce |=> backlight_on_out == ($past(regs[IDX_PULSE_CTRL][0]) ^ $past(regs[IDX_PULSE_CTRL][1]));
	endproperty
	a_on_level: assert property (p_on_level) else $error("backlight-on level wrong");

	property p_pulse_static;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && !backlight_control_on) |=> backlight_pulse_out == $past(regs[IDX_PULSE_CTRL][2]);
	endproperty
	a_pulse_static: assert property (p_pulse_static) else $error("static pulse level wrong");

	property p_pulse_wave;
		@(posedge sys_clk) disable iff (sys_rst)
		(ce && backlight_control_on) |=>
			backlight_pulse_out == ($past(wave) ^ $past(regs[IDX_PULSE_CTRL][2]));
	endproperty
	a_pulse_wave: assert property (p_pulse_wave) else $error("pulse waveform wrong");

	property p_res_legal;
		@(posedge sys_clk) disable iff (sys_rst)
		act_res <= RES_CODE_MAX && res_cnt <= res_max && pre_cnt <= act_div;
	endproperty
	a_res_legal: assert property (p_res_legal) else $error("period counter out of range");

	property p_boundary_only;
		@(posedge sys_clk) disable iff (sys_rst)
		($changed(act_div) || $changed(act_res)) |->
			$past(boundary || !backlight_control_on) && $past(ce);
	endproperty
	a_boundary_only: assert property (p_boundary_only) else $error("divider changed midperiod");

	property p_mean_sel;
		@(posedge sys_clk) disable iff (sys_rst)
		enh_cfg.image_mean == (regs[IDX_ENH_FUNC][6] ? auto_mean_value : regs[IDX_MEAN]);
	endproperty
	a_mean_sel: assert property (p_mean_sel) else $error("image mean source wrong");

	property p_contrast_dir;
		@(posedge sys_clk) disable iff (sys_rst)
		!(enh_cfg.contrast_increase && enh_cfg.contrast_decrease) &&
		(enh_cfg.contrast_decrease == (regs[IDX_ENH_FUNC][3] && regs[IDX_ENH_FUNC][2]));
	endproperty
	a_contrast_dir: assert property (p_contrast_dir) else $error("contrast direction wrong");

	property p_mid_level;
		@(posedge sys_clk) disable iff (sys_rst)
		(regs[IDX_SRE_MID][3:2] == 2'b11) |-> enh_cfg.sunlight_mid_level == BPE_LVL_MED;
	endproperty
	a_mid_level: assert property (p_mid_level) else $error("mid level decode wrong");

	property p_frame_bound;
		@(posedge sys_clk) disable iff (sys_rst)
		dim_active |-> frame_cnt < frame_len && dim_step <= step_last;
	endproperty
	a_frame_bound: assert property (p_frame_bound) else $error("dimming counter overrun");

	property p_sleep_write;
		@(posedge sys_clk) disable iff (sys_rst)
		(access && pwrite && pstrb[0] && hit[IDX_DIVIDER] && sleep_in) |=>
			regs[IDX_DIVIDER] == $past(pwdata[7:0]);
	endproperty
	a_sleep_write: assert property (p_sleep_write) else $error("write lost in sleep");

endmodule

// file: verification/bpe_led_model.sv
`timescale 1ns/10ps
// Backlight LED driver model on the pulse pin. It only loads the pin, so it drives nothing back;
// it times every period from one rising edge to the next and reports the high time within it.
module bpe_led_model (
	input  wire logic sys_clk,
	input  wire logic pulse_in,
	output int        period,
	output int        high_cycles,
	output int        rises
);
	int   cnt;  // Cycles since the last rising edge.
	int   hcnt; // High cycles since the last rising edge.
	logic last; // Pin level seen at the previous edge.

	initial begin
		cnt = 0;
		hcnt = 0;
		last = 1'b0;
		period = 0;
		high_cycles = 0;
		rises = 0;
	end

	// A rising edge closes one period; the edge cycle itself opens the next one.
	always @(posedge sys_clk) begin
		if (pulse_in === 1'b1 && last === 1'b0) begin
			period <= cnt;
			high_cycles <= hcnt;
			rises <= rises + 1;
			cnt <= 1;
			hcnt <= 1;
		end else begin
			cnt <= cnt + 1;
			hcnt <= hcnt + ((pulse_in === 1'b1) ? 1 : 0);
		end
		last <= pulse_in;
	end
endmodule

// file: verification/backlight_pwm_enhance_ctrl_test.sv
`timescale 1ns/10ps
module backlight_pwm_enhance_ctrl_test;
	import bpe_pkg::*;
	logic        sys_clk = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, auto_mean_value = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic [3:0]  pstrb = 0;
	logic        pready, pslverr, rerr, bl_ctrl = 0, sleep_in = 0, frame_tick = 0, dim_start = 0;
	logic [11:0] pulse_duty = 0;
	logic        backlight_on_out, backlight_pulse_out, dim_active;
	logic [8:0]  dim_step;
	bpe_enh_t    enh_cfg;
	int          model_reg [REG_COUNT]; // Register image kept by the bench.
	int          num_errors = 0, compares = 0, period, high_cycles, rises, n, e, p;
	logic [7:0]  v;
	// Pulse runs: code, polarity and divider; code 5 is reserved and must leave code 4 in force.
	int          runs [8][3] = '{'{4,0,0}, '{4,1,0}, '{4,0,1}, '{5,0,0}, '{3,0,0}, '{2,0,0},
	                             '{1,0,0}, '{0,0,0}};
	int          frames [3] = '{1, 5, 8};

	bpe_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .backlight_control_on(bl_ctrl),
		.sleep_in(sleep_in), .pulse_duty(pulse_duty), .auto_mean_value(auto_mean_value),
		.frame_tick(frame_tick), .dim_start(dim_start), .backlight_on_out(backlight_on_out),
		.backlight_pulse_out(backlight_pulse_out), .dim_active(dim_active), .dim_step(dim_step),
		.enh_cfg(enh_cfg));
	bpe_led_model i_led (.sys_clk(sys_clk), .pulse_in(backlight_pulse_out), .period(period),
		.high_cycles(high_cycles), .rises(rises));

	// Free-running 100 MHz system clock.
	always #5 sys_clk = ~sys_clk;

	// Counts every comparison and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Single place where the run ends.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer; it opens one edge later so a released psel never rises in the same step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'(d);
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			num_errors++;
			finish_test();
		end
	endtask

	// Register write; the model keeps only writable bits, and only when byte lane 0 is strobed.
	task automatic wr_reg(input int i, input logic [7:0] d, input logic [3:0] s);
		apb(1'b1, {REG_OFFSET[i][5:0], 2'b00}, d, s);
		if (s[0])
			model_reg[i] = int'((d & REG_WMASK[i]) | REG_FIXED[i]);
	endtask

	task automatic rd_chk(input int i);
		apb(1'b0, {REG_OFFSET[i][5:0], 2'b00}, 8'h00, 4'h0);
		check("register", 32'(model_reg[i]), rdata);
		check("pslverr", 32'h0000_0000, 32'(rerr));
	endtask

	// Waits for a number of rising edges on the pulse pin, with a bound.
	task automatic wait_rises(input int cnt);
		int r0;
		int k;
		r0 = rises;
		for (k = 0; k < 40000 && rises < r0 + cnt; k++)
			@(posedge sys_clk);
		if (rises < r0 + cnt) begin
			num_errors++;
			finish_test();
		end
	endtask

	initial begin
		void'($urandom(32'hdecc));
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// The host has already selected command page 2; this block decodes no page.
		for (int i = 0; i < REG_COUNT; i++)
			model_reg[i] = int'(REG_RESET[i]);
		for (int i = 0; i < REG_COUNT; i++)
			rd_chk(i);
		// Random writes with random strobes, every other one in sleep; the first
		// pass always strobes lane 0, so a divider write in sleep is certain.
		for (int r = 0; r < 3; r++) for (int i = 0; i < REG_COUNT; i++) begin
			sleep_in <= 1'(i + r);
			wr_reg(i, 8'($urandom), 4'($urandom) | 4'(r == 0));
			rd_chk(i);
		end
		apb(1'b0, 8'h20, 8'h00, 4'h0);
		check("unmapped err", 32'h0000_0001, 32'(rerr));
		check("unmapped data", 32'h0000_0000, rdata);
		$display("register test done");
		for (int k = 0; k < 4; k++) begin
			wr_reg(IDX_PULSE_CTRL, 8'h40 | 8'(k), 4'h1);
			repeat (2) @(posedge sys_clk);
			check("backlight on", 32'(k[0] ^ k[1]), 32'(backlight_on_out));
		end
		// Control off: the pin must sit at the polarity level whatever the duty says.
		for (int k = 0; k < 2; k++) begin
			pulse_duty <= 12'($urandom);
			wr_reg(IDX_PULSE_CTRL, 8'h40 | 8'(k << 2), 4'h1);
			repeat (50) @(posedge sys_clk);
			check("static pin", 32'(k), 32'(backlight_pulse_out));
		end
		$display("backlight output test done");
		pulse_duty <= 12'h400;
		for (int k = 0; k < 8; k++) begin
			wr_reg(IDX_DIVIDER, 8'(runs[k][2]), 4'h1);
			wr_reg(IDX_PULSE_CTRL, 8'((runs[k][0] << 4) | (runs[k][1] << 2)), 4'h1);
			// Switch on once the first settings are loaded, so the long reset period never runs.
			if (k == 0) begin
				repeat (2) @(posedge sys_clk);
				bl_ctrl <= 1'b1;
			end
			wait_rises(3);
			e = (runs[k][0] > 4) ? 4 : runs[k][0];
			p = (runs[k][2] + 1) * (4096 >> e) * SYS_MHZ / SRC_MHZ;
			check("period", 32'(p), 32'(period));
			n = (runs[k][1] != 0) ? p * 3 / 4 : p / 4;
			if (runs[k][2] == 0)
				check("high time", 32'h0000_0001, 32'(high_cycles >= n - 1 && high_cycles <= n + 1));
			// Clock enable low must freeze the pin and the period counters for longer than a period.
			if (k == 0) begin
				ce <= 1'b0;
				repeat (2) @(posedge sys_clk);
				n = rises;
				e = int'(backlight_pulse_out);
				repeat (900) @(posedge sys_clk);
				check("frozen pin", 32'(e), 32'(backlight_pulse_out));
				check("frozen rises", 32'(n), 32'(rises));
				ce <= 1'b1;
			end
		end
		bl_ctrl <= 1'b0;
		$display("pulse test done");
		for (int k = 0; k < 8; k++) begin
			auto_mean_value <= 8'($urandom);
			wr_reg(IDX_ENH_FUNC, 8'($urandom), 4'h1);
			wr_reg(IDX_MEAN, 8'($urandom), 4'h1);
			wr_reg(IDX_SAT_PROT, 8'($urandom), 4'h1);
			wr_reg(IDX_CN_LEVEL, 8'($urandom), 4'h1);
			v = 8'($urandom);
			v[3:2] = 2'(k);
			wr_reg(IDX_SRE_MID, v, 4'h1);
			wr_reg(IDX_SRE_EN, 8'($urandom), 4'h1);
			wr_reg(IDX_SRE_STEPS, 8'($urandom), 4'h1);
			wr_reg(IDX_SRE_GAIN, 8'($urandom), 4'h1);
			@(posedge sys_clk);
			check("oversat", 32'(model_reg[IDX_SAT_PROT][2]), 32'(enh_cfg.oversat_protect_enable));
			check("skin", 32'(model_reg[IDX_SAT_PROT][1]), 32'(enh_cfg.skin_protect_enable));
			n = model_reg[IDX_ENH_FUNC][6] ? int'(auto_mean_value) : model_reg[IDX_MEAN];
			check("mean", 32'(n), 32'(enh_cfg.image_mean));
			check("mean mode", 32'({model_reg[IDX_ENH_FUNC][6], model_reg[IDX_ENH_FUNC][3]}),
				32'({enh_cfg.auto_mean, enh_cfg.contrast_enable}));
			e = model_reg[IDX_ENH_FUNC][3] ? (model_reg[IDX_ENH_FUNC][2] ? 1 : 2) : 0;
			check("direction", 32'(e),
				32'({enh_cfg.contrast_increase, enh_cfg.contrast_decrease}));
			check("contrast", 32'(model_reg[IDX_CN_LEVEL][1:0]), 32'(enh_cfg.contrast_level));
			check("sharp", 32'(model_reg[IDX_ENH_FUNC][1]), 32'(enh_cfg.sharpness_enable));
			n = (k % 4 == 1) ? 1 : (k % 4 == 2) ? 2 : 0;
			check("mid level", 32'(n), 32'(enh_cfg.sunlight_mid_level));
			n = model_reg[IDX_SRE_EN];
			check("sre enables", 32'({n[7], n[4], n[3], n[2]}),
				32'({enh_cfg.sunlight_hysteresis_enable, enh_cfg.sunlight_dimming_enable,
				enh_cfg.sunlight_satcomp_enable, enh_cfg.sunlight_contrast_enable}));
			check("sre fields", 32'({model_reg[IDX_SRE_STEPS][6:4], 8'(model_reg[IDX_SRE_GAIN])}),
				32'({enh_cfg.sunlight_offset_value, enh_cfg.sunlight_satcomp_gain,
				enh_cfg.sunlight_hysteresis_limit}));
		end
		$display("enhancement test done");
		// Dimming runs for 2, 4 and 8 steps; a disabled run must not start at all.
		for (int c = 0; c < 4; c++) begin
			wr_reg(IDX_SRE_EN, (c < 3) ? 8'h1c : 8'h0c, 4'h1);
			wr_reg(IDX_SRE_STEPS, 8'(c % 3), 4'h1);
			wr_reg(IDX_SRE_FRAMES, 8'(frames[c % 3]), 4'h1);
			dim_start <= 1'b1;
			@(posedge sys_clk);
			dim_start <= 1'b0;
			@(posedge sys_clk);
			check("dim active", 32'(c < 3), 32'(dim_active));
			n = 0;
			while (dim_active === 1'b1 && n < 600) begin
				frame_tick <= 1'b1;
				@(posedge sys_clk);
				frame_tick <= 1'b0;
				repeat (2) @(posedge sys_clk);
				n++;
			end
			e = (c < 3) ? (2 << c) * ((frames[c] < 3) ? 2 : frames[c]) : 0;
			check("dim frames", 32'(e), 32'(n));
			if (c < 3)
				check("dim step", 32'((2 << c) - 1), 32'(dim_step));
		end
		$display("dimming test done");
		finish_test();
	end
endmodule
